// File: hdl/rtc_pkg.sv
// Purpose: Shared constants for the timekeeping counter and periodic tick block.
// Assumes: Registers sit one per aligned 32-bit APB word at byte address four times the index.
// Notes: Sync channels 0 to 3 equal the bit positions in the counter busy register; channel 4 is bit 0 of the tick busy register.
package rtc_pkg;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_CNT_IEN = 6'h02;
  localparam logic [5:0] IDX_CNT_FLAGS = 6'h03;
  localparam logic [5:0] IDX_TEMP = 6'h04;
  localparam logic [5:0] IDX_CNT_DBG = 6'h05;
  localparam logic [5:0] IDX_SRC_SEL = 6'h07;
  localparam logic [5:0] IDX_COUNT = 6'h08;
  localparam logic [5:0] IDX_PERIOD = 6'h0A;
  localparam logic [5:0] IDX_MATCH = 6'h0C;
  localparam logic [5:0] IDX_TICK_CTRL = 6'h10;
  localparam logic [5:0] IDX_TICK_BUSY = 6'h11;
  localparam logic [5:0] IDX_TICK_IEN = 6'h12;
  localparam logic [5:0] IDX_TICK_FLAG = 6'h13;
  localparam logic [5:0] IDX_TICK_DBG = 6'h15;
  localparam int RUN_STDBY_BIT = 7;
  localparam int PRESC_LSB = 3;
  localparam int PRESC_W = 4;
  localparam int PERIOD_LSB = 3;
  localparam int ENABLE_BIT = 0;
  localparam int WRAP_BIT = 0;
  localparam int MATCH_BIT = 1;
  localparam int DBG_RUN_BIT = 0;
  localparam logic [7:0] CTRL_MASK = 8'hF9;
  localparam logic [7:0] TICK_CTRL_MASK = 8'h79;
  localparam int CH_CTRL = 0;
  localparam int CH_COUNT = 1;
  localparam int CH_PERIOD = 2;
  localparam int CH_MATCH = 3;
  localparam int CH_TICK = 4;
  localparam int SYNC_CH = 5;
  localparam int SYNC_EDGES = 2;
  localparam logic [1:0] SYNC_LAST = 2'(SYNC_EDGES - 1);
  localparam int PRE_W = 16;
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] MATCH_RST = 16'h0000;
endpackage

// File: hdl/pin_sync.sv
// Purpose: Brings an asynchronous pin into the pclk domain and marks its rising edges.
// Assumes: The pin stays at each level for at least three pclk cycles.
// Notes: A change is accepted only when the second and third stages agree.
`timescale 1ns/10ps
module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign level = level_q;
  assign rise = (s2_q == s3_q) && s3_q && !level_q;
endmodule

// File: hdl/rtc_counter_periodic_timer.sv
// Purpose: 16-bit wrapping counter with match, plus a periodic tick timer, behind an APB slave.
// Assumes: The timekeeping clock arrives on a pin far slower than pclk; sleep and halt are pclk-domain levels.
// Notes: Writes to control, count, period, match and tick control reach the counting logic
// Notes: only after two timekeeping edges, with the matching busy bit set meanwhile.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module rtc_counter_periodic_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [rtc_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timekeeping_clk,
  input wire logic sleep_standby,
  input wire logic debug_halt,
  output logic counter_irq,
  output logic tick_irq,
  output logic tick_level
);
  logic tk_rise, aligned, setup_ph, wr_ok, pslverr_q, cnt_dbg_q, tick_ien_q, tick_flag_q, tick_dbg_q;
  logic tick_level_q, tick_level_d, tick_rise, counter_irq_q, tick_irq_q, cnt_en_act, cnt_run;
  logic tick_en_act, tick_halt, tick_run, cnt_tick, tick_clr;
  logic [5:0] idx;
  logic [31:0] rd_data, prdata_q;
  logic [7:0] ctrl_sw_q, ctrl_act_q, temp_q, tick_ctrl_sw_q, tick_ctrl_act_q;
  logic [1:0] cnt_ien_q, cnt_flags_q, src_sel_q, cnt_set, cnt_clr;
  logic [15:0] count_sw_q, count_q, period_sw_q, period_act_q, match_sw_q, match_act_q;
  logic [rtc_pkg::SYNC_CH-1:0] sync_busy_q, sync_wr, sync_done;
  logic [1:0] sync_stage_q [rtc_pkg::SYNC_CH];
  logic [rtc_pkg::PRE_W-1:0] pre_q;
  logic [3:0] presc, tick_sel;

  function automatic logic known_idx(input logic [5:0] i);
    logic k;
    k = 1'b0;
    case (i)
      rtc_pkg::IDX_CTRL, rtc_pkg::IDX_STATUS, rtc_pkg::IDX_CNT_IEN, rtc_pkg::IDX_CNT_FLAGS,
      rtc_pkg::IDX_TEMP, rtc_pkg::IDX_CNT_DBG, rtc_pkg::IDX_SRC_SEL, rtc_pkg::IDX_COUNT,
      rtc_pkg::IDX_PERIOD, rtc_pkg::IDX_MATCH, rtc_pkg::IDX_TICK_CTRL, rtc_pkg::IDX_TICK_BUSY,
      rtc_pkg::IDX_TICK_IEN, rtc_pkg::IDX_TICK_FLAG, rtc_pkg::IDX_TICK_DBG: k = 1'b1;
      default: k = 1'b0;
    endcase
    return k;
  endfunction

  // True when the low n bits of v are all ones, the last count of a divide-by-two-to-the-n.
  function automatic logic low_ones(input logic [rtc_pkg::PRE_W-1:0] v, input logic [3:0] n);
    logic [rtc_pkg::PRE_W-1:0] m;
    m = (16'h0001 << n) - 16'h0001;
    return (v & m) == m;
  endfunction

  pin_sync u_tk_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(timekeeping_clk),
    .level(),
    .rise(tk_rise)
  );

  // Bus side: zero wait states; read data is captured in the setup cycle.
  assign idx = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign setup_ph = psel && !penable;
  assign wr_ok = psel && penable && pwrite && aligned && known_idx(idx);
  assign pready = 1'b1;
  assign pslverr = pslverr_q && psel && penable;
  assign prdata = prdata_q;

  always_comb begin
    rd_data = 32'h0000_0000;
    case (idx)
      rtc_pkg::IDX_CTRL: rd_data = {24'h00_0000, ctrl_sw_q};
      rtc_pkg::IDX_STATUS: rd_data = {28'h000_0000, sync_busy_q[rtc_pkg::CH_MATCH:rtc_pkg::CH_CTRL]};
      rtc_pkg::IDX_CNT_IEN: rd_data = {30'h0000_0000, cnt_ien_q};
      rtc_pkg::IDX_CNT_FLAGS: rd_data = {30'h0000_0000, cnt_flags_q};
      rtc_pkg::IDX_TEMP: rd_data = {24'h00_0000, temp_q};
      rtc_pkg::IDX_CNT_DBG: rd_data = {31'h0000_0000, cnt_dbg_q};
      rtc_pkg::IDX_SRC_SEL: rd_data = {30'h0000_0000, src_sel_q};
      rtc_pkg::IDX_COUNT: rd_data = {16'h0000, count_q};
      rtc_pkg::IDX_PERIOD: rd_data = {16'h0000, period_sw_q};
      rtc_pkg::IDX_MATCH: rd_data = {16'h0000, match_sw_q};
      rtc_pkg::IDX_TICK_CTRL: rd_data = {24'h00_0000, tick_ctrl_sw_q};
      rtc_pkg::IDX_TICK_BUSY: rd_data = {31'h0000_0000, sync_busy_q[rtc_pkg::CH_TICK]};
      rtc_pkg::IDX_TICK_IEN: rd_data = {31'h0000_0000, tick_ien_q};
      rtc_pkg::IDX_TICK_FLAG: rd_data = {31'h0000_0000, tick_flag_q};
      rtc_pkg::IDX_TICK_DBG: rd_data = {31'h0000_0000, tick_dbg_q};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q <= (aligned && known_idx(idx)) ? rd_data : 32'h0000_0000;
      pslverr_q <= !(aligned && known_idx(idx));
    end
  end

  // Plain software registers; the busy registers have no write path at all.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sw_q <= rtc_pkg::REG8_RST;
      cnt_ien_q <= 2'b00;
      temp_q <= rtc_pkg::REG8_RST;
      cnt_dbg_q <= 1'b0;
      src_sel_q <= 2'b00;
      count_sw_q <= rtc_pkg::COUNT_RST;
      period_sw_q <= rtc_pkg::PERIOD_RST;
      match_sw_q <= rtc_pkg::MATCH_RST;
      tick_ctrl_sw_q <= rtc_pkg::REG8_RST;
      tick_ien_q <= 1'b0;
      tick_dbg_q <= 1'b0;
    end else if (wr_ok) begin
      case (idx)
        rtc_pkg::IDX_CTRL: ctrl_sw_q <= pwdata[7:0] & rtc_pkg::CTRL_MASK;
        rtc_pkg::IDX_CNT_IEN: cnt_ien_q <= pwdata[1:0];
        rtc_pkg::IDX_TEMP: temp_q <= pwdata[7:0];
        rtc_pkg::IDX_CNT_DBG: cnt_dbg_q <= pwdata[rtc_pkg::DBG_RUN_BIT];
        rtc_pkg::IDX_SRC_SEL: src_sel_q <= pwdata[1:0];
        rtc_pkg::IDX_COUNT: count_sw_q <= pwdata[15:0];
        rtc_pkg::IDX_PERIOD: period_sw_q <= pwdata[15:0];
        rtc_pkg::IDX_MATCH: match_sw_q <= pwdata[15:0];
        rtc_pkg::IDX_TICK_CTRL: tick_ctrl_sw_q <= pwdata[7:0] & rtc_pkg::TICK_CTRL_MASK;
        rtc_pkg::IDX_TICK_IEN: tick_ien_q <= pwdata[0];
        rtc_pkg::IDX_TICK_DBG: tick_dbg_q <= pwdata[rtc_pkg::DBG_RUN_BIT];
        default: tick_dbg_q <= tick_dbg_q;
      endcase
    end
  end

  // Crossing into the counting logic: each channel waits two timekeeping edges after a write.
  assign sync_wr[rtc_pkg::CH_CTRL] = wr_ok && (idx == rtc_pkg::IDX_CTRL);
  assign sync_wr[rtc_pkg::CH_COUNT] = wr_ok && (idx == rtc_pkg::IDX_COUNT);
  assign sync_wr[rtc_pkg::CH_PERIOD] = wr_ok && (idx == rtc_pkg::IDX_PERIOD);
  assign sync_wr[rtc_pkg::CH_MATCH] = wr_ok && (idx == rtc_pkg::IDX_MATCH);
  assign sync_wr[rtc_pkg::CH_TICK] = wr_ok && (idx == rtc_pkg::IDX_TICK_CTRL);

  always_comb begin
    for (int i = 0; i < rtc_pkg::SYNC_CH; i++) begin
      // A fresh write in the finishing cycle must not let the stale value through.
      sync_done[i] = sync_busy_q[i] && tk_rise && !sync_wr[i] && (sync_stage_q[i] == rtc_pkg::SYNC_LAST);
    end
  end

  // A write that lands during a transfer restarts it, so the newest value always wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_busy_q <= '0;
      for (int i = 0; i < rtc_pkg::SYNC_CH; i++) begin
        sync_stage_q[i] <= 2'b00;
      end
    end else begin
      for (int i = 0; i < rtc_pkg::SYNC_CH; i++) begin
        if (sync_wr[i]) begin
          sync_busy_q[i] <= 1'b1;
          sync_stage_q[i] <= 2'b00;
        end else if (sync_done[i]) begin
          sync_busy_q[i] <= 1'b0;
          sync_stage_q[i] <= 2'b00;
        end else if (sync_busy_q[i] && tk_rise) begin
          sync_stage_q[i] <= sync_stage_q[i] + 2'b01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_act_q <= rtc_pkg::REG8_RST;
      period_act_q <= rtc_pkg::PERIOD_RST;
      match_act_q <= rtc_pkg::MATCH_RST;
      tick_ctrl_act_q <= rtc_pkg::REG8_RST;
    end else begin
      if (sync_done[rtc_pkg::CH_CTRL]) begin
        ctrl_act_q <= ctrl_sw_q;
      end
      if (sync_done[rtc_pkg::CH_PERIOD]) begin
        period_act_q <= period_sw_q;
      end
      if (sync_done[rtc_pkg::CH_MATCH]) begin
        match_act_q <= match_sw_q;
      end
      if (sync_done[rtc_pkg::CH_TICK]) begin
        tick_ctrl_act_q <= tick_ctrl_sw_q;
      end
    end
  end

  assign cnt_en_act = ctrl_act_q[rtc_pkg::ENABLE_BIT];
  assign presc = ctrl_act_q[rtc_pkg::PRESC_LSB +: rtc_pkg::PRESC_W];
  // Halted without run-during-break, the counter stops and takes no further steps.
  assign cnt_run = cnt_en_act && !(sleep_standby && !ctrl_act_q[rtc_pkg::RUN_STDBY_BIT])
    && !(debug_halt && !cnt_dbg_q);
  assign tick_en_act = tick_ctrl_act_q[rtc_pkg::ENABLE_BIT];
  assign tick_sel = tick_ctrl_act_q[rtc_pkg::PERIOD_LSB +: 4];
  assign tick_halt = debug_halt && !tick_dbg_q;
  assign tick_run = tick_en_act && !tick_halt;

  // One prescaler chain serves both functions; it clears when both are disabled and holds while neither runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (!cnt_en_act && !tick_en_act) begin
      pre_q <= '0;
    end else if ((cnt_run || tick_run) && tk_rise) begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  assign cnt_tick = cnt_run && tk_rise && low_ones(pre_q, presc);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= rtc_pkg::COUNT_RST;
    end else if (sync_done[rtc_pkg::CH_COUNT]) begin
      count_q <= count_sw_q;
    end else if (cnt_tick) begin
      if (count_q == period_act_q) begin
        count_q <= 16'h0000;
      end else begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  always_comb begin
    cnt_set = 2'b00;
    cnt_set[rtc_pkg::WRAP_BIT] = cnt_tick && !sync_done[rtc_pkg::CH_COUNT] && (count_q == period_act_q);
    cnt_set[rtc_pkg::MATCH_BIT] = cnt_tick && !sync_done[rtc_pkg::CH_COUNT] && (count_q == match_act_q);
  end

  assign cnt_clr = (wr_ok && (idx == rtc_pkg::IDX_CNT_FLAGS)) ? pwdata[1:0] : 2'b00;
  assign tick_clr = wr_ok && (idx == rtc_pkg::IDX_TICK_FLAG) && pwdata[0];

  // For n above 0 the tick level is bit n of the chain, a square wave of period two to the n plus one cycles; n of 0 holds it low.
  assign tick_level_d = tick_run && (tick_sel != 4'h0) && pre_q[tick_sel];
  // After a break the chain resumes where it froze, or where the running counter took it, so a high bit comes back as a new edge.
  assign tick_rise = tick_level_d && !tick_level_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_level_q <= 1'b0;
    end else begin
      tick_level_q <= tick_level_d;
    end
  end

  // Set wins over a clear arriving in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_flags_q <= 2'b00;
      tick_flag_q <= 1'b0;
    end else begin
      cnt_flags_q <= (cnt_flags_q & ~cnt_clr) | cnt_set;
      tick_flag_q <= (tick_flag_q && !tick_clr) || tick_rise;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_irq_q <= 1'b0;
      tick_irq_q <= 1'b0;
    end else begin
      counter_irq_q <= |(cnt_flags_q & cnt_ien_q);
      tick_irq_q <= tick_flag_q && tick_ien_q;
    end
  end

  assign counter_irq = counter_irq_q;
  assign tick_irq = tick_irq_q;
  assign tick_level = tick_level_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ctrl_write;
    psel && penable && pwrite && (paddr == {rtc_pkg::IDX_CTRL, 2'b00});
  endsequence

  sequence s_ctrl_done;
    sync_busy_q[rtc_pkg::CH_CTRL] && tk_rise && (sync_stage_q[rtc_pkg::CH_CTRL] == rtc_pkg::SYNC_LAST);
  endsequence

  chk_wrap_flag_set: assert property (cnt_tick && !sync_done[rtc_pkg::CH_COUNT] && count_q == period_act_q
    |=> cnt_flags_q[rtc_pkg::WRAP_BIT] && count_q == 16'h0000)
    else $error("wrap did not set flag and clear count");
  chk_match_flag_set: assert property (cnt_tick && !sync_done[rtc_pkg::CH_COUNT] && count_q == match_act_q
    |=> cnt_flags_q[rtc_pkg::MATCH_BIT])
    else $error("match did not set flag");
  chk_tick_flag_edge: assert property (tick_rise |=> tick_flag_q && tick_level)
    else $error("tick edge did not set flag");
  chk_counter_irq_level: assert property (|(cnt_flags_q & cnt_ien_q) |=> counter_irq)
    else $error("counter request missing");
  chk_tick_irq_follow: assert property (!(tick_flag_q && tick_ien_q) |=> !tick_irq)
    else $error("tick request without enabled flag");
  chk_standby_stop: assert property (sleep_standby && !ctrl_act_q[rtc_pkg::RUN_STDBY_BIT] &&
    !sync_done[rtc_pkg::CH_COUNT] |=> $stable(count_q))
    else $error("counter moved in standby");
  chk_tick_sleep_run: assert property (tick_run && sleep_standby && tk_rise |=> pre_q == $past(pre_q) + 16'h0001)
    else $error("tick chain stopped in sleep");
  chk_ctrl_busy_set: assert property (s_ctrl_write |=> sync_busy_q[rtc_pkg::CH_CTRL]
    && sync_stage_q[rtc_pkg::CH_CTRL] == 2'b00 && ctrl_act_q == $past(ctrl_act_q))
    else $error("control write did not start transfer");
  chk_ctrl_apply: assert property (s_ctrl_done ##0 !sync_wr[rtc_pkg::CH_CTRL]
    |=> !sync_busy_q[rtc_pkg::CH_CTRL] && ctrl_act_q == $past(ctrl_sw_q))
    else $error("control transfer did not complete");
  chk_ctrl_busy_hold: assert property (sync_busy_q[rtc_pkg::CH_CTRL] && !tk_rise |=> sync_busy_q[rtc_pkg::CH_CTRL])
    else $error("busy cleared without timekeeping edge");
  chk_break_halt: assert property (debug_halt && !tick_dbg_q |=> !tick_level)
    else $error("tick output high while halted");
  chk_break_high: assert property ($fell(tick_halt) && tick_en_act && tick_sel != 4'h0 && pre_q[tick_sel]
    |=> tick_flag_q && tick_level)
    else $error("no edge after break");
  chk_break_low: assert property ($fell(tick_halt) && !pre_q[tick_sel] |=> !tick_level)
    else $error("tick high after low break");
  chk_presc_full: assert property (cnt_run && tk_rise && presc == 4'h0 |-> cnt_tick)
    else $error("undivided tick missing");
  chk_presc_max: assert property (cnt_tick && presc == 4'hF |-> pre_q[14:0] == 15'h7FFF)
    else $error("wrong divide by 32768");
  chk_status_read: assert property (setup_ph && paddr == {rtc_pkg::IDX_STATUS, 2'b00}
    |=> prdata == {28'h000_0000, $past(sync_busy_q[3:0])})
    else $error("status read mismatch");
  chk_count_hold: assert property (!cnt_run && !sync_done[rtc_pkg::CH_COUNT] |=> $stable(count_q))
    else $error("count changed while stopped");
  chk_flag_clear: assert property (tick_flag_q && tick_clr && !tick_rise |=> !tick_flag_q)
    else $error("tick flag not cleared");
  chk_busy_ro: assert property (psel && penable && pwrite && paddr == {rtc_pkg::IDX_STATUS, 2'b00}
    |=> sync_busy_q == ($past(sync_busy_q) & ~$past(sync_done)))
    else $error("busy register took a write");
endmodule

// File: verif/test_rtc_counter_periodic_timer.sv
// Purpose: Self-checking bench for the counter and periodic tick block, driven over APB.
// Assumes: Zero-wait APB slave; the timekeeping pin toggles every four pclk cycles.
// Notes: Live counts are allowed one step of slack, because the pin synchroniser adds a few cycles.
`timescale 1ns/10ps
module test_rtc_counter_periodic_timer;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd, c0;
  logic pready, pslverr, err, counter_irq, tick_irq, tick_level, lvl_q;
  logic timekeeping_clk = 1'b0;
  logic sleep_standby = 1'b0;
  logic debug_halt = 1'b0;
  logic [31:0] mdl [64];
  logic [5:0] map_q [$];
  logic [5:0] bad_q [$];
  logic [5:0] sidx [4] = '{6'h00, 6'h08, 6'h0A, 6'h0C};
  logic [31:0] sval [4] = '{32'h10, 32'h0, 32'h5, 32'h3};
  integer error_cnt = 0;
  integer cmp_count = 0;
  integer seed = 2352;
  integer div = 0;
  integer edges = 0;
  integer rises = 0;
  integer n, i, d, e;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    lvl_q <= tick_level;
    if (tick_level === 1'b1 && lvl_q === 1'b0) rises <= rises + 1;
    div <= (div == 3) ? 0 : div + 1;
    if (div == 3) timekeeping_clk <= ~timekeeping_clk;
    if (div == 3 && !timekeeping_clk) edges <= edges + 1;
  end
  rtc_counter_periodic_timer dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timekeeping_clk(timekeeping_clk), .sleep_standby(sleep_standby),
    .debug_halt(debug_halt), .counter_irq(counter_irq), .tick_irq(tick_irq), .tick_level(tick_level));
  function automatic logic [31:0] msk(input logic [5:0] idx);
    case (idx)
      rtc_pkg::IDX_CTRL: msk = {24'h000000, rtc_pkg::CTRL_MASK};
      rtc_pkg::IDX_TICK_CTRL: msk = {24'h000000, rtc_pkg::TICK_CTRL_MASK};
      rtc_pkg::IDX_TEMP: msk = 32'h000000FF;
      rtc_pkg::IDX_CNT_IEN, rtc_pkg::IDX_SRC_SEL: msk = 32'h00000003;
      rtc_pkg::IDX_CNT_DBG, rtc_pkg::IDX_TICK_DBG, rtc_pkg::IDX_TICK_IEN: msk = 32'h00000001;
      rtc_pkg::IDX_PERIOD, rtc_pkg::IDX_MATCH: msk = 32'h0000FFFF;
      default: msk = 32'h00000000;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // The model keeps only storable bits, so read-only and flag registers stay at zero in it.
  task automatic apb(input logic [5:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= {idx, 2'b00};
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr && err === 1'b0) mdl[idx] = wd & msk(idx);
  endtask
  task automatic wait_sync;
    n = 0;
    do begin
      apb(6'h01, 1'b0, 32'h0);
      c0 = rd;
      apb(6'h11, 1'b0, 32'h0);
      n = n + 1;
    end while ((c0 | rd) !== 32'h0 && n < 40);
    chk("sync busy", c0 | rd, 32'h0);
  endtask
  task automatic span;
    apb(6'h08, 1'b0, 32'h0);
    c0 = rd;
    e = edges;
    repeat (320) @(posedge pclk);
    apb(6'h08, 1'b0, 32'h0);
    d = (rd - c0) & 32'h0000FFFF;
    e = (edges - e) / 4;
  endtask
  task automatic near;
    chk("step count", (d >= e - 1 && d <= e + 1) ? 32'h1 : 32'h0, 32'h1);
  endtask
  task automatic wait_lvl(input logic v);
    n = 0;
    while (tick_level !== v && n < 100) begin
      @(posedge pclk);
      n = n + 1;
    end
    chk("tick level wait", {31'h0, tick_level}, {31'h0, v});
  endtask
  initial begin
    #150000;
    error_cnt = error_cnt + 1;
    conclude;
  end
  initial begin
    for (i = 0; i < 64; i = i + 1) mdl[i] = 32'h0;
    mdl[6'h0A] = 32'h0000FFFF;
    map_q = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h08, 6'h0A, 6'h0C, 6'h10, 6'h11, 6'h12, 6'h13, 6'h15};
    bad_q = '{6'h06, 6'h09, 6'h0E, 6'h14, 6'h3F};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (map_q[k]) begin
      apb(map_q[k], 1'b0, 32'h0);
      chk("reset value", rd, mdl[map_q[k]]);
    end
    foreach (bad_q[k]) begin
      apb(bad_q[k], 1'b1, 32'hFFFFFFFF);
      chk("unmapped error", {31'h0, err}, 32'h1);
      apb(bad_q[k], 1'b0, 32'h0);
      chk("unmapped read", {err, rd[30:0]}, 32'h80000000);
    end
    foreach (map_q[k]) apb(map_q[k], 1'b1, $random(seed));
    wait_sync;
    foreach (map_q[k]) if (!(map_q[k] inside {6'h03, 6'h08, 6'h13})) begin
      apb(map_q[k], 1'b0, 32'h0);
      chk("readback", rd, mdl[map_q[k]]);
    end
    apb(6'h00, 1'b1, 32'h0);
    apb(6'h10, 1'b1, 32'h0);
    apb(6'h05, 1'b1, 32'h0);
    apb(6'h15, 1'b1, 32'h0);
    wait_sync;
    for (i = 0; i < 4; i = i + 1) begin
      apb(sidx[i], 1'b1, sval[i]);
      apb(6'h01, 1'b0, 32'h0);
      chk("busy flag", rd, 32'h1 << i);
      wait_sync;
    end
    apb(6'h10, 1'b1, 32'h0);
    apb(6'h11, 1'b0, 32'h0);
    chk("tick busy", rd, 32'h1);
    wait_sync;
    apb(6'h02, 1'b1, 32'h3);
    apb(6'h03, 1'b1, 32'h3);
    apb(6'h00, 1'b1, 32'h1);
    wait_sync;
    n = 0;
    do begin
      apb(6'h08, 1'b0, 32'h0);
      chk("count bound", {31'h0, rd <= 32'h5}, 32'h1);
      apb(6'h03, 1'b0, 32'h0);
      n = n + 1;
    end while (rd !== 32'h3 && n < 60);
    chk("counter flags", rd, 32'h3);
    chk("counter irq", {31'h0, counter_irq}, 32'h1);
    apb(6'h00, 1'b1, 32'h0);
    wait_sync;
    apb(6'h03, 1'b1, 32'h0);
    apb(6'h03, 1'b0, 32'h0);
    chk("flags kept", rd, 32'h3);
    apb(6'h03, 1'b1, 32'h2);
    apb(6'h03, 1'b0, 32'h0);
    chk("flag cleared", rd, 32'h1);
    apb(6'h02, 1'b1, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq masked", {31'h0, counter_irq}, 32'h0);
    span;
    chk("count held", d, 32'h0);
    apb(6'h0A, 1'b1, 32'h0000FFFF);
    apb(6'h00, 1'b1, 32'h11);
    wait_sync;
    span;
    near;
    sleep_standby <= 1'b1;
    span;
    chk("standby stop", d, 32'h0);
    apb(6'h00, 1'b1, 32'h91);
    wait_sync;
    span;
    near;
    sleep_standby <= 1'b0;
    debug_halt <= 1'b1;
    span;
    chk("break stop", d, 32'h0);
    apb(6'h05, 1'b1, 32'h1);
    span;
    near;
    debug_halt <= 1'b0;
    apb(6'h12, 1'b1, 32'h1);
    apb(6'h10, 1'b1, 32'h09);
    wait_sync;
    sleep_standby <= 1'b1;
    d = rises;
    repeat (320) @(posedge pclk);
    d = rises - d;
    e = 10;
    near;
    chk("tick irq", {31'h0, tick_irq}, 32'h1);
    debug_halt <= 1'b1;
    d = rises;
    repeat (100) @(posedge pclk);
    chk("tick low in break", {31'(rises - d), tick_level}, 32'h0);
    debug_halt <= 1'b0;
    wait_lvl(1'b1);
    debug_halt <= 1'b1;
    apb(6'h13, 1'b1, 32'h1);
    debug_halt <= 1'b0;
    repeat (12) @(posedge pclk);
    apb(6'h13, 1'b0, 32'h0);
    chk("restart flag", rd, 32'h1);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    debug_halt <= 1'b1;
    apb(6'h13, 1'b1, 32'h1);
    debug_halt <= 1'b0;
    apb(6'h13, 1'b0, 32'h0);
    chk("quiet restart", rd, 32'h0);
    conclude;
  end
endmodule
